// ### dv/mcc_host.sv
`timescale 1ns/100ps
module mcc_host (
  input  wire logic             core_clk_i,
  input  wire logic [7:0]       rdata_i,
  input  wire logic             rvalid_i,
  output mcc_pkg::mcc_ser_req_s ser_o
);
  int gap = 0;
  initial ser_o = '0;
  task automatic put(input logic p, input logic w, input logic [7:0] d);
    repeat (gap + 1) @(posedge core_clk_i);
    ser_o <= '{ptr_wr: p, wr: w, rd: 1'b0, data: d};
    @(posedge core_clk_i);
    ser_o <= '0;
  endtask : put
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a);
    put(1'b0, 1'b1, d);
  endtask : wr
  // A missing answer reads as unknown, so the caller's compare fails.
  task automatic get(input logic [7:0] a, output logic [7:0] d);
    put(1'b1, 1'b0, a);
    @(posedge core_clk_i);
    ser_o.rd <= 1'b1;
    @(posedge core_clk_i);
    ser_o.rd <= 1'b0;
    // The answer stands for one cycle only, one edge after the read is taken.
    repeat (1) @(posedge core_clk_i);
    #1;
    d = rvalid_i ? rdata_i : 8'hXX;
  endtask : get
endmodule : mcc_host

// ### dv/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb;
  localparam int PCYC = 20;
  logic                  clk = 0, rstn = 0, tick = 0, over = 0, cool = 0;
  logic                  res_wr = 0, tsel = 0, ext_rst = 0, rvalid, rst_oe, thi = 0;
  logic                  th_oe, tp_o, tp_oe, nmode, int_n, run, lowp, shdn;
  logic                  asel, rst_o, th_o;
  logic [15:0]           stat_set = '0;
  logic [7:0]            res_addr = '0, res_data = '0, nand_in = 8'hFF, d;
  logic [7:0]            rdata, aout, trip_i, trip_e;
  mcc_pkg::mcc_ser_req_s ser;
  int                    fail_count = 0, num_checks = 0;
  // Four-state so that an unknown pin level spoils the count instead of vanishing.
  integer                n;
  always #20 clk = ~clk;
  mcc_host h (.core_clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .ser_o(ser));
  mcc_ctrl #(.PULSE_CYC(PCYC)) uut (.core_clk_i(clk), .resetn_i(rstn), .ser_i(ser),
    .ser_rdata_o(rdata), .ser_rvalid_o(rvalid), .stat_set_i(stat_set),
    .meas_tick_i(tick), .hw_over_i(over), .hw_cool_i(cool), .temp_high_i(thi),
    .temp_low_i(1'b0), .res_wr_i(res_wr), .res_addr_i(res_addr), .res_data_i(res_data),
    .nand_in_i(nand_in), .test_sel_pin_i(tsel), .rst_pin_i(~(rst_oe | ext_rst)),
    .rst_pin_o(rst_o), .rst_pin_oe_o(rst_oe), .thermal_alert_pin_i(~th_oe),
    .thermal_alert_pin_o(th_o), .thermal_alert_pin_oe_o(th_oe),
    .test_out_addr_select_pin_i(tp_oe ? tp_o : 1'b1),
    .test_out_addr_select_pin_o(tp_o), .test_out_addr_select_pin_oe_o(tp_oe),
    .addr_sel_o(asel), .nand_mode_o(nmode), .int_n_o(int_n), .monitor_run_o(run),
    .low_power_o(lowp), .shutdown_o(shdn), .aout_o(aout), .trip_int_o(trip_i),
    .trip_ext_o(trip_e));
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  task automatic ticks(input int k, input logic o, input logic c);
    repeat (k)
    begin
      @(posedge clk);
      {tick, over, cool} <= {1'b1, o, c};
      @(posedge clk);
      tick <= 1'b0;
    end
    settle();
  endtask : ticks
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  // The whole sequence needs well under 2000 cycles; this allows many times that.
  initial
  begin
    #2_000_000;
    fail_count++;
    give_verdict();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    settle();
    settle();
    `CHK(nmode, 1'b0)
    `CHK({asel, rst_o, th_o}, 3'b100)
    h.get(mcc_pkg::A_CFG1, d);
    `CHK(d, mcc_pkg::CFG1_RST)
    `CHK({run, lowp, int_n, aout}, {3'b011, mcc_pkg::AOUT_FULL})
    `CHK({trip_i, trip_e}, {mcc_pkg::FIX_INT_VAL, mcc_pkg::FIX_EXT_VAL})
    h.wr(mcc_pkg::A_CFG1, 8'h03);
    settle();
    `CHK({run, lowp}, 2'b10)
    @(posedge clk);
    stat_set <= 16'h0001;
    @(posedge clk);
    stat_set <= '0;
    settle();
    `CHK(int_n, 1'b0)
    h.wr(mcc_pkg::A_CFG1, 8'h0B);
    settle();
    `CHK(int_n, 1'b1)
    h.get(mcc_pkg::A_STAT1, d);
    `CHK(d, 8'h01)
    h.wr(mcc_pkg::A_CFG2, 8'h01);
    h.wr(mcc_pkg::A_CFG1, 8'h03);
    @(posedge clk);
    stat_set <= mcc_pkg::TEMP_BITS & 16'h0010;
    @(posedge clk);
    stat_set <= '0;
    settle();
    `CHK(int_n, 1'b1)
    h.gap = 2;
    h.wr(mcc_pkg::A_CFG2, 8'h00);
    settle();
    `CHK(int_n, 1'b0)
    h.wr(mcc_pkg::A_CFG1, 8'h01);
    settle();
    `CHK(int_n, 1'b1)
    h.gap = 0;
    h.get(mcc_pkg::A_STAT1, d);
    h.wr(mcc_pkg::A_CFG2, 8'h08);
    h.wr(mcc_pkg::A_CFG1, 8'h05);
    ticks(2, 1'b1, 1'b0);
    `CHK(th_oe, 1'b0)
    ticks(1, 1'b1, 1'b0);
    `CHK(th_oe, 1'b1)
    h.wr(mcc_pkg::A_CFG1, 8'h45);
    settle();
    `CHK(th_oe, 1'b0)
    h.wr(mcc_pkg::A_CFG1, 8'h05);
    ticks(2, 1'b0, 1'b1);
    `CHK(th_oe, 1'b1)
    ticks(1, 1'b0, 1'b1);
    `CHK(th_oe, 1'b0)
    @(posedge clk);
    {res_wr, res_addr, res_data} <= {1'b1, 8'h20, 8'hA5};
    @(posedge clk);
    res_wr <= 1'b0;
    h.get(8'h20, d);
    `CHK(d, 8'hA5)
    h.wr(mcc_pkg::A_TRIP_INT, 8'h30);
    h.wr(mcc_pkg::A_CFG2, 8'h06);
    h.wr(mcc_pkg::A_TRIP_INT, 8'h20);
    h.wr(mcc_pkg::A_TRIP_EXT, 8'h21);
    settle();
    `CHK({trip_i, trip_e}, {8'h30, mcc_pkg::FIX_EXT_VAL})
    @(posedge clk);
    thi <= 1'b1;
    @(posedge clk);
    thi <= 1'b0;
    settle();
    `CHK(th_oe, 1'b1)
    h.get(mcc_pkg::A_STAT2, d);
    `CHK(th_oe, 1'b0)
    h.wr(mcc_pkg::A_CFG1, 8'h00);
    h.wr(mcc_pkg::A_TEST, 8'h01);
    settle();
    `CHK({shdn, aout, trip_i}, {1'b1, mcc_pkg::AOUT_OFF, 8'h30})
    h.wr(mcc_pkg::A_TEST, 8'h00);
    h.wr(mcc_pkg::A_AOUT, 8'h5A);
    h.wr(mcc_pkg::A_MASK1, 8'h7F);
    settle();
    `CHK({shdn, aout}, {1'b0, 8'h5A})
    h.wr(mcc_pkg::A_CFG1, 8'h80);
    settle();
    h.get(mcc_pkg::A_MASK1, d);
    `CHK({d, aout}, {8'h00, 8'h5A})
    h.get(mcc_pkg::A_CFG1, d);
    `CHK(d, mcc_pkg::CFG1_RST)
    h.wr(mcc_pkg::A_CFG1, 8'h10);
    n = 0;
    repeat (40) @(posedge clk) n += rst_oe;
    `CHK(n, 0)
    h.wr(mcc_pkg::A_MASK2, 8'h80);
    h.wr(mcc_pkg::A_CFG1, 8'h10);
    n = 0;
    repeat (40) @(posedge clk) n += rst_oe;
    `CHK(n, PCYC)
    h.get(mcc_pkg::A_CFG1, d);
    `CHK(d[4], 1'b0)
    @(posedge clk);
    ext_rst <= 1'b1;
    repeat (4) @(posedge clk);
    ext_rst <= 1'b0;
    settle();
    h.get(mcc_pkg::A_MASK2, d);
    `CHK(d, 8'h00)
    @(posedge clk);
    rstn <= 1'b0;
    tsel <= 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    settle();
    settle();
    `CHK({nmode, tp_oe, tp_o}, 3'b110)
    @(posedge clk);
    nand_in <= 8'hFE;
    settle();
    `CHK(tp_o, 1'b1)
    give_verdict();
  end
endmodule : tb

// ### src/mcc_ctrl.sv
`timescale 1ns/100ps
module mcc_ctrl #(
  parameter int NAND_W    = 8,
  parameter int PULSE_CYC = mcc_pkg::RST_PULSE_CYC
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  input  wire mcc_pkg::mcc_ser_req_s ser_i,
  output logic [7:0]                ser_rdata_o,
  output logic                      ser_rvalid_o,
  input  wire logic [15:0]          stat_set_i,
  input  wire logic                 meas_tick_i,
  input  wire logic                 hw_over_i,
  input  wire logic                 hw_cool_i,
  input  wire logic                 temp_high_i,
  input  wire logic                 temp_low_i,
  input  wire logic                 res_wr_i,
  input  wire logic [7:0]           res_addr_i,
  input  wire logic [7:0]           res_data_i,
  input  wire logic [NAND_W-1:0]    nand_in_i,
  input  wire logic                 test_sel_pin_i,
  input  wire logic                 rst_pin_i,
  output logic                      rst_pin_o,
  output logic                      rst_pin_oe_o,
  input  wire logic                 thermal_alert_pin_i,
  output logic                      thermal_alert_pin_o,
  output logic                      thermal_alert_pin_oe_o,
  input  wire logic                 test_out_addr_select_pin_i,
  output logic                      test_out_addr_select_pin_o,
  output logic                      test_out_addr_select_pin_oe_o,
  output logic                      addr_sel_o,
  output logic                      nand_mode_o,
  output logic                      int_n_o,
  output logic                      monitor_run_o,
  output logic                      low_power_o,
  output logic                      shutdown_o,
  output logic [7:0]                aout_o,
  output logic [7:0]                trip_int_o,
  output logic [7:0]                trip_ext_o
);
  localparam int SW = NAND_W + 4;
  localparam int CW = $clog2(PULSE_CYC + 1);

  function automatic logic addr_is_local(input logic [7:0] a);
    logic hit;
    hit = (a == mcc_pkg::A_CFG1) || (a == mcc_pkg::A_CFG2) || (a == mcc_pkg::A_STAT1)
       || (a == mcc_pkg::A_STAT2) || (a == mcc_pkg::A_MIR1) || (a == mcc_pkg::A_MIR2)
       || (a == mcc_pkg::A_FIX_INT) || (a == mcc_pkg::A_FIX_EXT);
    for (int i = 0; i < mcc_pkg::LOC_N; i++)
    begin
      hit = hit || (a == mcc_pkg::LOC_ADDR[i]);
    end
    return hit;
  endfunction : addr_is_local

  // Pins are asynchronous to the core clock.
  logic [SW-1:0] sync1_r;
  logic [SW-1:0] sync2_r;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_r <= {SW{1'b1}};
      sync2_r <= {SW{1'b1}};
    end
    else
    begin
      sync1_r <= {test_sel_pin_i, rst_pin_i, thermal_alert_pin_i,
                  test_out_addr_select_pin_i, nand_in_i};
      sync2_r <= sync1_r;
    end
  end
  logic test_sel_s;
  logic rst_pin_s;
  logic thermal_alert_pin_pin_s;
  logic addr_pin_s;
  logic nand_red;
  assign test_sel_s  = sync2_r[SW-1];
  assign rst_pin_s   = sync2_r[SW-2];
  assign thermal_alert_pin_pin_s = sync2_r[SW-3];
  assign addr_pin_s  = sync2_r[SW-4];
  assign nand_red    = ~&sync2_r[NAND_W-1:0];

  logic [7:0]           ptr_r, ptr_nxt;
  mcc_pkg::mcc_cfg1_s   cfg1_r, cfg1_nxt;
  mcc_pkg::mcc_cfg2_s   cfg2_r, cfg2_nxt;
  logic [1:0]           lock_r, lock_nxt;
  logic [15:0]          stat_r, stat_nxt, mir_r, mir_nxt;
  logic [7:0]           loc_r [mcc_pkg::LOC_N];
  logic [7:0]           loc_nxt [mcc_pkg::LOC_N];
  mcc_pkg::mcc_rp_e     rp_r, rp_nxt;
  logic [CW-1:0]        rp_cnt_r, rp_cnt_nxt;
  logic [1:0]           strap_cnt_r, strap_cnt_nxt;
  logic                 strap_done_r, strap_done_nxt, nand_mode_nxt;
  logic [1:0]           ocnt_r, ocnt_nxt, ccnt_r, ccnt_nxt;
  logic                 hw_thermal_alert_pin_r, hw_thermal_alert_pin_nxt, sw_thermal_alert_pin_r, sw_thermal_alert_pin_nxt;
  logic [2:0]           toe_hist_r;
  logic                 rd_d_r, loc_hit_r;
  logic [7:0]           loc_q_r, loc_q_nxt, mem_q;
  logic                 pin_rst, wr_now, rd_now, rp_done, int_any, thermal_alert_pin_act;
  logic [15:0]          stat_set, stat_rdclr, int_src;

  assign wr_now  = ser_i.wr;
  assign rd_now  = ser_i.rd;
  // Our own pulse and its settling time are not taken as an external reset.
  assign pin_rst = !rst_pin_s && rp_r == mcc_pkg::RP_IDLE && strap_done_r;
  assign rp_done = rp_r == mcc_pkg::RP_DRIVE && rp_cnt_r == CW'(PULSE_CYC - 1);
  assign stat_set = stat_set_i | (16'(!thermal_alert_pin_pin_s && toe_hist_r == 3'h0)
                    << (8 + mcc_pkg::STAT2_THERMAL_ALERT_PIN_BIT));
  assign stat_rdclr = {{8{rd_now && ptr_r == mcc_pkg::A_STAT2}},
                       {8{rd_now && ptr_r == mcc_pkg::A_STAT1}}};
  assign int_src = stat_r & ~{loc_r[mcc_pkg::L_MASK2], loc_r[mcc_pkg::L_MASK1]}
                   & ~(cfg2_r.temp_mask ? mcc_pkg::TEMP_BITS : 16'h0000);
  assign int_any = |int_src;
  assign thermal_alert_pin_act = cfg2_r.acpi ? hw_thermal_alert_pin_r : (hw_thermal_alert_pin_r || sw_thermal_alert_pin_r);

  always_comb
  begin
    ptr_nxt  = ptr_r;
    cfg1_nxt = cfg1_r;
    cfg2_nxt = cfg2_r;
    lock_nxt = lock_r;
    stat_nxt = stat_r;
    mir_nxt  = mir_r;
    loc_nxt  = loc_r;
    if (ser_i.ptr_wr)
    begin
      ptr_nxt = ser_i.data;
    end
    if (pin_rst)
    begin
      cfg1_nxt = mcc_pkg::CFG1_RST;
      cfg2_nxt = mcc_pkg::CFG2_RST;
      stat_nxt = {2{mcc_pkg::STAT_RST}};
      mir_nxt  = {2{mcc_pkg::STAT_RST}};
      loc_nxt  = mcc_pkg::LOC_RST;
    end
    // soft init keeps test and analog output
    else if (cfg1_r.init)
    begin
      cfg1_nxt = mcc_pkg::CFG1_RST;
      cfg2_nxt = mcc_pkg::CFG2_RST;
      stat_nxt = {2{mcc_pkg::STAT_RST}};
      mir_nxt  = {2{mcc_pkg::STAT_RST}};
      for (int i = 0; i < mcc_pkg::LOC_N; i++)
      begin
        if (i != mcc_pkg::L_TEST && i != mcc_pkg::L_AOUT)
        begin
          loc_nxt[i] = mcc_pkg::LOC_RST[i];
        end
      end
    end
    else
    begin
      // status set wins over read clear
      stat_nxt = (stat_r & ~stat_rdclr) | stat_set;
      mir_nxt  = mir_r | stat_set;
      if (wr_now && ptr_r == mcc_pkg::A_CFG1)
      begin
        cfg1_nxt = ser_i.data;
        cfg1_nxt.rst_pulse = cfg1_r.rst_pulse || (ser_i.data[4] && rp_r == mcc_pkg::RP_IDLE
                             && loc_r[mcc_pkg::L_MASK2][mcc_pkg::MASK2_RST_EN_BIT]);
      end
      if (wr_now && ptr_r == mcc_pkg::A_CFG2)
      begin
        cfg2_nxt = ser_i.data;
      end
      for (int i = 0; i < mcc_pkg::LOC_N; i++)
      begin
        if (wr_now && ptr_r == mcc_pkg::LOC_ADDR[i]
            && !(i == mcc_pkg::L_TRIPI && lock_r[0])
            && !(i == mcc_pkg::L_TRIPE && lock_r[1]))
        begin
          loc_nxt[i] = ser_i.data;
        end
      end
      if (rp_done)
      begin
        cfg1_nxt.rst_pulse = 1'b0;
      end
    end
    // lock is only undone by power-on reset
    if (wr_now && ptr_r == mcc_pkg::A_CFG2 && !pin_rst && !cfg1_r.init)
    begin
      lock_nxt = lock_r | ser_i.data[2:1];
    end
  end

  always_comb
  begin
    rp_nxt     = rp_r;
    rp_cnt_nxt = rp_cnt_r + CW'(1);
    case (rp_r)
      mcc_pkg::RP_IDLE:
      begin
        rp_cnt_nxt = '0;
        if (cfg1_r.rst_pulse)
        begin
          rp_nxt = mcc_pkg::RP_DRIVE;
        end
      end
      mcc_pkg::RP_DRIVE:
      begin
        if (rp_done)
        begin
          rp_nxt     = mcc_pkg::RP_GUARD;
          rp_cnt_nxt = '0;
        end
      end
      default:
      begin
        if (rp_cnt_r == CW'(3))
        begin
          rp_nxt = mcc_pkg::RP_IDLE;
        end
      end
    endcase
  end

  // strap sampled once after synchronisers fill
  always_comb
  begin
    strap_cnt_nxt  = strap_cnt_r;
    strap_done_nxt = strap_done_r;
    nand_mode_nxt  = nand_mode_o;
    if (!strap_done_r)
    begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      if (strap_cnt_r == 2'(mcc_pkg::STRAP_WAIT))
      begin
        strap_done_nxt = 1'b1;
        nand_mode_nxt  = test_sel_s;
      end
    end
  end

  always_comb
  begin
    ocnt_nxt     = ocnt_r;
    ccnt_nxt     = ccnt_r;
    hw_thermal_alert_pin_nxt = hw_thermal_alert_pin_r;
    if (meas_tick_i)
    begin
      ocnt_nxt = hw_over_i ? ((ocnt_r == 2'h3) ? ocnt_r : ocnt_r + 2'h1) : 2'h0;
      ccnt_nxt = hw_cool_i ? ((ccnt_r == 2'h3) ? ccnt_r : ccnt_r + 2'h1) : 2'h0;
      if (hw_over_i && ocnt_r == 2'(mcc_pkg::HW_CONSEC - 1))
      begin
        hw_thermal_alert_pin_nxt = 1'b1;
      end
      else if (hw_cool_i && ccnt_r == 2'(mcc_pkg::HW_CONSEC - 1))
      begin
        hw_thermal_alert_pin_nxt = 1'b0;
      end
    end
    // thermostat alert cleared by clear bit, status read or low limit
    sw_thermal_alert_pin_nxt = (sw_thermal_alert_pin_r || temp_high_i) && !cfg1_r.thermal_alert_pin_clr && !temp_low_i
                   && !(rd_now && ptr_r == mcc_pkg::A_STAT2);
    loc_q_nxt = mem_q;
    for (int i = 0; i < mcc_pkg::LOC_N; i++)
    begin
      if (ptr_r == mcc_pkg::LOC_ADDR[i])
      begin
        loc_q_nxt = loc_r[i];
      end
    end
    if (ptr_r == mcc_pkg::A_CFG1)
    begin
      loc_q_nxt = cfg1_r;
    end
    else if (ptr_r == mcc_pkg::A_CFG2)
    begin
      loc_q_nxt = {cfg2_r[7:3], lock_r, cfg2_r[0]};
    end
    else if (ptr_r == mcc_pkg::A_STAT1)
    begin
      loc_q_nxt = stat_r[7:0];
    end
    else if (ptr_r == mcc_pkg::A_STAT2)
    begin
      loc_q_nxt = stat_r[15:8];
    end
    else if (ptr_r == mcc_pkg::A_MIR1)
    begin
      loc_q_nxt = mir_r[7:0];
    end
    else if (ptr_r == mcc_pkg::A_MIR2)
    begin
      loc_q_nxt = mir_r[15:8];
    end
    else if (ptr_r == mcc_pkg::A_FIX_INT)
    begin
      loc_q_nxt = mcc_pkg::FIX_INT_VAL;
    end
    else if (ptr_r == mcc_pkg::A_FIX_EXT)
    begin
      loc_q_nxt = mcc_pkg::FIX_EXT_VAL;
    end
  end

  // power-on defaults; stopped with alarm clear set
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ptr_r <= 8'h00;
      cfg1_r <= mcc_pkg::CFG1_RST;
      cfg2_r <= mcc_pkg::CFG2_RST;
      lock_r <= 2'h0;
      stat_r <= {2{mcc_pkg::STAT_RST}};
      mir_r <= {2{mcc_pkg::STAT_RST}};
      loc_r <= mcc_pkg::LOC_RST;
      rp_r <= mcc_pkg::RP_IDLE;
      rp_cnt_r <= '0;
      strap_cnt_r <= 2'h0;
      strap_done_r <= 1'b0;
      nand_mode_o <= 1'b0;
      ocnt_r <= 2'h0;
      ccnt_r <= 2'h0;
      hw_thermal_alert_pin_r <= 1'b0;
      sw_thermal_alert_pin_r <= 1'b0;
      toe_hist_r <= 3'h0;
      rd_d_r <= 1'b0;
      loc_hit_r <= 1'b0;
      loc_q_r <= 8'h00;
      ser_rdata_o <= 8'h00;
      ser_rvalid_o <= 1'b0;
      rst_pin_oe_o <= 1'b0;
      thermal_alert_pin_oe_o <= 1'b0;
      test_out_addr_select_pin_o <= 1'b1;
      test_out_addr_select_pin_oe_o <= 1'b0;
      addr_sel_o <= 1'b0;
      int_n_o <= 1'b1;
      monitor_run_o <= 1'b0;
      low_power_o <= 1'b1;
      shutdown_o <= 1'b0;
      aout_o <= mcc_pkg::AOUT_FULL;
      trip_int_o <= mcc_pkg::FIX_INT_VAL;
      trip_ext_o <= mcc_pkg::FIX_EXT_VAL;
    end
    else
    begin
      ptr_r <= ptr_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      lock_r <= lock_nxt;
      stat_r <= stat_nxt;
      mir_r <= mir_nxt;
      loc_r <= loc_nxt;
      rp_r <= rp_nxt;
      rp_cnt_r <= rp_cnt_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      strap_done_r <= strap_done_nxt;
      nand_mode_o <= nand_mode_nxt;
      ocnt_r <= ocnt_nxt;
      ccnt_r <= ccnt_nxt;
      hw_thermal_alert_pin_r <= hw_thermal_alert_pin_nxt;
      sw_thermal_alert_pin_r <= sw_thermal_alert_pin_nxt;
      toe_hist_r <= {toe_hist_r[1:0], thermal_alert_pin_oe_o};
      rd_d_r <= rd_now;
      loc_hit_r <= addr_is_local(ptr_r);
      loc_q_r <= loc_q_nxt;
      ser_rdata_o <= loc_hit_r ? loc_q_r : mem_q;
      ser_rvalid_o <= rd_d_r;
      rst_pin_oe_o <= rp_r == mcc_pkg::RP_DRIVE;
      thermal_alert_pin_oe_o <= cfg1_r.thermal_alert_pin_en && !cfg1_r.thermal_alert_pin_clr && thermal_alert_pin_act;
      test_out_addr_select_pin_o <= nand_red;
      test_out_addr_select_pin_oe_o <= nand_mode_o;
      addr_sel_o <= addr_pin_s;
      int_n_o <= !(cfg1_r.int_en && !cfg1_r.int_clr && int_any);
      monitor_run_o <= cfg1_r.start && !cfg1_r.int_clr && !nand_mode_o;
      low_power_o <= !cfg1_r.start;
      shutdown_o <= !cfg1_r.start && loc_r[mcc_pkg::L_TEST][mcc_pkg::TEST_SHDN_BIT];
      aout_o <= (!cfg1_r.start && loc_r[mcc_pkg::L_TEST][mcc_pkg::TEST_SHDN_BIT])
                ? mcc_pkg::AOUT_OFF : (thermal_alert_pin_act ? mcc_pkg::AOUT_FULL
                : loc_r[mcc_pkg::L_AOUT]);
      trip_int_o <= loc_r[mcc_pkg::L_TRIPI];
      trip_ext_o <= loc_r[mcc_pkg::L_TRIPE];
    end
  end

  assign rst_pin_o           = 1'b0;
  assign thermal_alert_pin_o = 1'b0;

  // results written by the datapath take priority
  mcc_regmem u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (res_wr_i || (wr_now && !addr_is_local(ptr_r))),
    .waddr_i    (res_wr_i ? res_addr_i : ptr_r),
    .wdata_i    (res_wr_i ? res_data_i : ser_i.data),
    .raddr_i    (ptr_r),
    .rdata_o    (mem_q)
  );

  logic [CW:0] oe_len_r;
  always_ff @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      oe_len_r <= '0;
    end
    else
    begin
      oe_len_r <= rst_pin_oe_o ? oe_len_r + (CW+1)'(1) : '0;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_third_over;
    cfg2_r.acpi && meas_tick_i && hw_over_i && ocnt_r == 2'h2;
  endsequence
  sequence s_init_req;
    cfg1_r.init && !pin_rst;
  endsequence

  a_pulse_enable: assert property ($rose(rst_pin_oe_o) |->
    $past(loc_r[mcc_pkg::L_MASK2][mcc_pkg::MASK2_RST_EN_BIT], 3))
    else $error("reset pulse without enable");
  a_pulse_length: assert property ($fell(rst_pin_oe_o) |->
    oe_len_r == (CW+1)'(PULSE_CYC)) else $error("reset pulse length wrong");
  a_pulse_selfclr: assert property ($fell(rst_pin_oe_o) |->
    !cfg1_r.rst_pulse) else $error("reset pulse bit not cleared");
  a_nand_output: assert property (nand_mode_o |=>
    test_out_addr_select_pin_o == $past(nand_red) && test_out_addr_select_pin_oe_o)
    else $error("NAND output wrong");
  a_int_clear_hold: assert property (cfg1_r.int_clr |=>
    int_n_o && !monitor_run_o) else $error("alarm clear not holding");
  a_alarm_or: assert property (cfg1_r.int_en && !cfg1_r.int_clr && int_any |=>
    !int_n_o) else $error("alarm not asserted");
  a_trip_lock: assert property (lock_r[0] && wr_now && ptr_r == mcc_pkg::A_TRIP_INT
    && !pin_rst && !cfg1_r.init |=> $stable(loc_r[mcc_pkg::L_TRIPI]))
    else $error("locked trip point written");
  a_acpi_three: assert property (s_third_over |-> ##1 hw_thermal_alert_pin_r
    ##1 (thermal_alert_pin_oe_o == (cfg1_r.thermal_alert_pin_en && !cfg1_r.thermal_alert_pin_clr)))
    else $error("thermal alert after three trips wrong");
  a_soft_init: assert property (s_init_req |=> cfg1_r == mcc_pkg::CFG1_RST
    && $stable(loc_r[mcc_pkg::L_TEST])) else $error("soft init wrong");
  a_shutdown_on: assert property (!cfg1_r.start
    && loc_r[mcc_pkg::L_TEST][mcc_pkg::TEST_SHDN_BIT] |=> shutdown_o
    && aout_o == mcc_pkg::AOUT_OFF) else $error("shutdown not entered");
endmodule : mcc_ctrl

// ### src/mcc_pkg.sv
package mcc_pkg;
  localparam int CLK_HZ        = 25_000_000;
  localparam int RST_PULSE_MS  = 20;
  localparam int RST_PULSE_CYC = CLK_HZ / 1000 * RST_PULSE_MS;
  localparam int HW_CONSEC     = 3;
  localparam int STRAP_WAIT    = 3;

  localparam logic [7:0] A_TRIP_INT = 8'h13;
  localparam logic [7:0] A_TRIP_EXT = 8'h14;
  localparam logic [7:0] A_TEST     = 8'h15;
  localparam logic [7:0] A_CHMODE   = 8'h16;
  localparam logic [7:0] A_FIX_INT  = 8'h17;
  localparam logic [7:0] A_FIX_EXT  = 8'h18;
  localparam logic [7:0] A_AOUT     = 8'h19;
  localparam logic [7:0] A_CFG1     = 8'h40;
  localparam logic [7:0] A_STAT1    = 8'h41;
  localparam logic [7:0] A_STAT2    = 8'h42;
  localparam logic [7:0] A_MASK1    = 8'h43;
  localparam logic [7:0] A_MASK2    = 8'h44;
  localparam logic [7:0] A_INTR     = 8'h46;
  localparam logic [7:0] A_FANDIV   = 8'h47;
  localparam logic [7:0] A_CFG2     = 8'h4A;
  localparam logic [7:0] A_MIR1     = 8'h4C;
  localparam logic [7:0] A_MIR2     = 8'h4D;

  localparam int MASK2_RST_EN_BIT = 7;
  localparam int TEST_SHDN_BIT    = 0;
  localparam int STAT2_THERMAL_ALERT_PIN_BIT  = 5;

  localparam logic [7:0]  CFG1_RST    = 8'h08;
  localparam logic [7:0]  CFG2_RST    = 8'h00;
  localparam logic [7:0]  STAT_RST    = 8'h00;
  localparam logic [7:0]  FIX_INT_VAL = 8'h46;
  localparam logic [7:0]  FIX_EXT_VAL = 8'h55;
  localparam logic [7:0]  AOUT_FULL   = 8'hFF;
  localparam logic [7:0]  AOUT_OFF    = 8'h00;
  localparam logic [15:0] TEMP_BITS   = 16'h0030;

  // Plain read/write registers that carry a power-on default.
  localparam int L_MASK1 = 0;
  localparam int L_MASK2 = 1;
  localparam int L_TEST  = 2;
  localparam int L_AOUT  = 3;
  localparam int L_TRIPI = 4;
  localparam int L_TRIPE = 5;
  localparam int L_CHMOD = 6;
  localparam int L_FDIV  = 7;
  localparam int L_INTR  = 8;
  localparam int LOC_N   = 9;
  localparam logic [7:0] LOC_ADDR [LOC_N] = '{A_MASK1, A_MASK2, A_TEST, A_AOUT,
    A_TRIP_INT, A_TRIP_EXT, A_CHMODE, A_FANDIV, A_INTR};
  localparam logic [7:0] LOC_RST [LOC_N] = '{8'h00, 8'h00, 8'h00, 8'hFF,
    8'h46, 8'h55, 8'h00, 8'h00, 8'h00};

  typedef struct packed {
    logic init;
    logic thermal_alert_pin_clr;
    logic spare5;
    logic rst_pulse;
    logic int_clr;
    logic thermal_alert_pin_en;
    logic int_en;
    logic start;
  } mcc_cfg1_s;

  typedef struct packed {
    logic [3:0] spare;
    logic       acpi;
    logic [1:0] lock;
    logic       temp_mask;
  } mcc_cfg2_s;

  typedef struct packed {
    logic       ptr_wr;
    logic       wr;
    logic       rd;
    logic [7:0] data;
  } mcc_ser_req_s;

  typedef enum logic [1:0] {RP_IDLE, RP_DRIVE, RP_GUARD} mcc_rp_e;
endpackage : mcc_pkg

// ### src/mcc_regmem.sv
`timescale 1ns/100ps
// Storage for value and limit registers; these have no defined reset value.
module mcc_regmem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          core_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule : mcc_regmem
